// *** pkg/ssf_pkg.sv ***
/*
  Constants for the special setting objects of a linear servo drive:
  object indices, reset values, ranges, bit positions and timings.
  Assumes a 40 MHz drive control clock.
*/
package ssf_pkg;

  // Clock and times
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned INIT_BASE_MS = 1500;
  localparam int unsigned INIT_STEP_MS = 100;
  localparam int unsigned STEP_CYCLES = MS_CYCLES * INIT_STEP_MS;
  localparam int unsigned INIT_BASE_STEPS = INIT_BASE_MS / INIT_STEP_MS;
  localparam int unsigned STEPS_PER_S = MS_PER_S / INIT_STEP_MS;
  localparam int unsigned S_PER_MIN = 60;
  localparam int unsigned SAVE_MIN = 30;

  // Object indices
  localparam logic [15:0] IDX_FEXP = 16'h3610;
  localparam logic [15:0] IDX_STOP_TIME = 16'h3614;
  localparam logic [15:0] IDX_OVS_LEVEL = 16'h3615;
  localparam logic [15:0] IDX_INIT_EXTRA = 16'h3618;
  localparam logic [15:0] IDX_COMP_GAIN = 16'h3623;
  localparam logic [15:0] IDX_FILT_TIME = 16'h3624;
  localparam logic [15:0] IDX_EST_SEL = 16'h3631;
  localparam logic [15:0] IDX_STATUS = 16'h36F0;

  // Reset values
  localparam logic [15:0] RST_FEXP = 16'h0040;
  localparam logic [15:0] RST_STOP_TIME = 16'h00C8;
  localparam logic [15:0] RST_OVS_LEVEL = 16'h0000;
  localparam logic [15:0] RST_INIT_EXTRA = 16'h0000;
  localparam logic [15:0] RST_COMP_GAIN = 16'h0000;
  localparam logic [15:0] RST_FILT_TIME = 16'h0035;
  localparam logic [15:0] RST_EST_SEL = 16'h0000;

  // Ranges
  localparam int FEXP_MAX = 511;
  localparam int STOP_TIME_MAX = 1000;
  localparam int OVS_LEVEL_MAX = 20000;
  localparam int INIT_EXTRA_MAX = 100;
  localparam int COMP_GAIN_MIN = -100;
  localparam int COMP_GAIN_MAX = 100;
  localparam int FILT_TIME_MIN = 10;
  localparam int FILT_TIME_MAX = 2500;
  localparam int EST_SEL_MAX = 3;

  // Function expansion bits
  localparam int FB_SPD_OBS = 0;
  localparam int FB_DIST_OBS = 1;
  localparam int FB_DIST_GAIN1 = 2;
  localparam int FB_CUR_RESP = 4;
  localparam int FB_CMD_COMP = 6;
  localparam int FB_INP_LIMIT = 7;
  localparam logic [15:0] FEXP_MASK = 16'h00D7;

  // Overspeed default factor, 1.2 as 12/10
  localparam int unsigned OVS_NUM = 12;
  localparam int unsigned OVS_DEN = 10;

  // Status object bits
  localparam int ST_INIT_DONE = 0;
  localparam int ST_TIMEOUT = 1;
  localparam int ST_OVERSPEED = 2;

  typedef enum logic [1:0] {
    SSF_EST_STOP,
    SSF_EST_MINUTE,
    SSF_EST_SECOND,
    SSF_EST_OPTIMUM
  } ssf_est_t;

endpackage : ssf_pkg

// *** src/ssf_tick.sv ***
/*
  Free running divider giving a one-cycle tick every DIV clocks.
  Assumes run is synchronous; dropping run restarts the period.
*/
`timescale 1ns/100ps
module ssf_tick #(
  parameter int unsigned DIV = 40000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Control
  input wire logic run,
  output logic tick
);

  localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] count;

  generate
    if (DIV < 2) begin : g_bad
      $error("ssf_tick: DIV must be at least 2");
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!resetn || !run) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count == LAST) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule : ssf_tick

// *** src/ssf_top.sv ***
/*
  Special setting objects of a linear servo drive: object store,
  function expansion gating, immediate stop supervision, power-on
  delay and load estimation pacing. Assumes the motion controller
  writes objects through the object port and all inputs are
  synchronous to ref_clk.
*/
`timescale 1ns/100ps

// Functional notes
// - Bit 0 enables speed observer, bit 1 enables disturbance observer.
// - Bit 2 set limits disturbance observer to gain set 1.
// - Bit 4 enables current response improvement.
// - Bit 6 holds last good target on communication error in CSP.
// - Bit 7 clear: done outputs follow position error or command only.
// - Immediate stop longer than allowed milliseconds forces error; default 200.
// - Allowed time zero disables the stop time-out.
// - Speed above stop overspeed level during stop raises overspeed error.
// - Level zero uses 1.2 times maximum motor speed.
// - Initialization completes after 1.5 s plus setting times 0.1 s.
// - Disturbance compensation gain is signed percent, -100 to 100.
// - Disturbance filter constant in 0.01 ms, 10 to 2500, default 53.
// - Estimation speed selected 0 to 3 while autotuning runs.
// - Estimation results saved to nonvolatile memory every 30 minutes.
// - Select 0 stops, 1 minute, 2 second, 3 optimum from changes.
module ssf_top #(
  parameter int unsigned MS_CYCLES = ssf_pkg::MS_CYCLES,
  parameter int unsigned STEP_CYCLES = ssf_pkg::STEP_CYCLES,
  parameter int unsigned MAX_SPEED = 5000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Object access port
  input wire logic obj_req,
  input wire logic obj_we,
  input wire logic [15:0] obj_index,
  input wire logic [15:0] obj_wdata,
  output logic obj_ack,
  output logic obj_err,
  output logic [15:0] obj_rdata,
  // Observer and loop enables
  input wire logic gain1_sel,
  output logic speed_observer_en,
  output logic dist_observer_en,
  output logic current_resp_en,
  output logic [15:0] dist_comp_gain,
  output logic [15:0] dist_filter_time,
  // Cyclic position command
  input wire logic csp_mode,
  input wire logic target_valid,
  input wire logic comm_error,
  input wire logic [31:0] target_pos,
  output logic [31:0] cmd_target_pos,
  output logic cmd_compensating,
  // Positioning complete
  input wire logic inp_raw_first,
  input wire logic inp_raw_second,
  input wire logic pole_method_estimate,
  input wire logic pole_est_done,
  output logic positioning_done_first,
  output logic positioning_done_second,
  // Immediate stop supervision
  input wire logic imm_stop_active,
  input wire logic [15:0] motor_speed,
  input wire logic err_clear,
  output logic stop_timeout_err,
  output logic overspeed2_err,
  // Power-on
  output logic init_done,
  // Load estimation
  input wire logic autotune_en,
  input wire logic load_change,
  output logic [1:0] load_est_mode,
  output logic load_est_strobe,
  output logic nv_save_strobe
);

  localparam int unsigned OVS_DEFAULT =
    MAX_SPEED * ssf_pkg::OVS_NUM / ssf_pkg::OVS_DEN;
  localparam logic [15:0] OVS_DEF16 = 16'(OVS_DEFAULT);
  localparam logic [7:0] INIT_BASE = 8'(ssf_pkg::INIT_BASE_STEPS);
  localparam logic [3:0] STEP_LAST = 4'(ssf_pkg::STEPS_PER_S - 1);
  localparam logic [5:0] SEC_LAST = 6'(ssf_pkg::S_PER_MIN - 1);
  localparam logic [4:0] MIN_LAST = 5'(ssf_pkg::SAVE_MIN - 1);

  generate
    if (OVS_DEFAULT > 65535 || MAX_SPEED == 0) begin : g_bad_speed
      $error("ssf_top: MAX_SPEED out of range");
    end
    if (MS_CYCLES < 2 || STEP_CYCLES < 2) begin : g_bad_div
      $error("ssf_top: tick periods too short");
    end
  endgenerate

  // Object store
  logic [15:0] fexp;
  logic [15:0] stop_time;
  logic [15:0] ovs_level;
  logic [15:0] init_extra;
  logic [15:0] comp_gain;
  logic [15:0] filt_time;
  logic [15:0] est_sel;

  // Internal state
  logic [31:0] last_good_pos;
  logic [10:0] stop_ms;
  logic [7:0] init_steps;
  logic [3:0] step_cnt;
  logic [5:0] sec_cnt;
  logic [4:0] min_cnt;
  logic ms_tick;
  logic step_tick;
  logic sec_tick;
  logic min_tick;
  logic [15:0] ovs_thresh;
  logic wr_ok;
  logic idx_known;
  logic [15:0] rd_value;
  logic [15:0] status_word;
  logic inp_gate;
  ssf_pkg::ssf_est_t est_mode;

  // Time bases
  ssf_tick #(
    .DIV(MS_CYCLES)
  ) u_ms_tick (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .run(imm_stop_active),
    .tick(ms_tick)
  );

  ssf_tick #(
    .DIV(STEP_CYCLES)
  ) u_step_tick (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .run(1'b1),
    .tick(step_tick)
  );

  // Range check of a write; out of range values are refused
  always_comb begin
    idx_known = 1'b1;
    wr_ok = 1'b0;
    unique case (obj_index)
      ssf_pkg::IDX_FEXP:
        wr_ok = $signed(obj_wdata) >= 0 &&
                $signed(obj_wdata) <= ssf_pkg::FEXP_MAX;
      ssf_pkg::IDX_STOP_TIME:
        wr_ok = $signed(obj_wdata) >= 0 &&
                $signed(obj_wdata) <= ssf_pkg::STOP_TIME_MAX;
      ssf_pkg::IDX_OVS_LEVEL:
        wr_ok = $signed(obj_wdata) >= 0 &&
                $signed(obj_wdata) <= ssf_pkg::OVS_LEVEL_MAX;
      ssf_pkg::IDX_INIT_EXTRA:
        wr_ok = $signed(obj_wdata) >= 0 &&
                $signed(obj_wdata) <= ssf_pkg::INIT_EXTRA_MAX;
      ssf_pkg::IDX_COMP_GAIN:
        wr_ok = $signed(obj_wdata) >= ssf_pkg::COMP_GAIN_MIN &&
                $signed(obj_wdata) <= ssf_pkg::COMP_GAIN_MAX;
      ssf_pkg::IDX_FILT_TIME:
        wr_ok = $signed(obj_wdata) >= ssf_pkg::FILT_TIME_MIN &&
                $signed(obj_wdata) <= ssf_pkg::FILT_TIME_MAX;
      ssf_pkg::IDX_EST_SEL:
        wr_ok = $signed(obj_wdata) >= 0 &&
                $signed(obj_wdata) <= ssf_pkg::EST_SEL_MAX;
      ssf_pkg::IDX_STATUS:
        wr_ok = 1'b0;
      default:
        idx_known = 1'b0;
    endcase
  end

  always_comb begin
    status_word = '0;
    status_word[ssf_pkg::ST_INIT_DONE] = init_done;
    status_word[ssf_pkg::ST_TIMEOUT] = stop_timeout_err;
    status_word[ssf_pkg::ST_OVERSPEED] = overspeed2_err;
  end

  always_comb begin
    unique case (obj_index)
      ssf_pkg::IDX_FEXP: rd_value = fexp;
      ssf_pkg::IDX_STOP_TIME: rd_value = stop_time;
      ssf_pkg::IDX_OVS_LEVEL: rd_value = ovs_level;
      ssf_pkg::IDX_INIT_EXTRA: rd_value = init_extra;
      ssf_pkg::IDX_COMP_GAIN: rd_value = comp_gain;
      ssf_pkg::IDX_FILT_TIME: rd_value = filt_time;
      ssf_pkg::IDX_EST_SEL: rd_value = est_sel;
      ssf_pkg::IDX_STATUS: rd_value = status_word;
      default: rd_value = '0;
    endcase
  end

  // Object writes
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fexp <= ssf_pkg::RST_FEXP;
      stop_time <= ssf_pkg::RST_STOP_TIME;
      ovs_level <= ssf_pkg::RST_OVS_LEVEL;
      init_extra <= ssf_pkg::RST_INIT_EXTRA;
      comp_gain <= ssf_pkg::RST_COMP_GAIN;
      filt_time <= ssf_pkg::RST_FILT_TIME;
      est_sel <= ssf_pkg::RST_EST_SEL;
    end else if (obj_req && obj_we && wr_ok) begin
      unique case (obj_index)
        // Reserved bits are dropped so they can steer nothing
        ssf_pkg::IDX_FEXP: fexp <= obj_wdata & ssf_pkg::FEXP_MASK;
        ssf_pkg::IDX_STOP_TIME: stop_time <= obj_wdata;
        ssf_pkg::IDX_OVS_LEVEL: ovs_level <= obj_wdata;
        ssf_pkg::IDX_INIT_EXTRA: init_extra <= obj_wdata;
        ssf_pkg::IDX_COMP_GAIN: comp_gain <= obj_wdata;
        ssf_pkg::IDX_FILT_TIME: filt_time <= obj_wdata;
        ssf_pkg::IDX_EST_SEL: est_sel <= obj_wdata;
        default: ;
      endcase
    end
  end

  // Object answers, one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      obj_ack <= 1'b0;
      obj_err <= 1'b0;
      obj_rdata <= '0;
    end else begin
      obj_ack <= obj_req;
      obj_err <= obj_req && (!idx_known || (obj_we && !wr_ok));
      if (obj_req && !obj_we) begin
        obj_rdata <= rd_value;
      end
    end
  end

  // Loop enables and compensation settings
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      speed_observer_en <= 1'b0;
      dist_observer_en <= 1'b0;
      current_resp_en <= 1'b0;
      dist_comp_gain <= ssf_pkg::RST_COMP_GAIN;
      dist_filter_time <= ssf_pkg::RST_FILT_TIME;
    end else begin
      speed_observer_en <= fexp[ssf_pkg::FB_SPD_OBS];
      dist_observer_en <= fexp[ssf_pkg::FB_DIST_OBS] &&
        (!fexp[ssf_pkg::FB_DIST_GAIN1] || gain1_sel);
      current_resp_en <= fexp[ssf_pkg::FB_CUR_RESP];
      dist_comp_gain <= comp_gain;
      dist_filter_time <= filt_time;
    end
  end

  // Target command with hold on communication error
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      last_good_pos <= '0;
      cmd_target_pos <= '0;
      cmd_compensating <= 1'b0;
    end else if (target_valid) begin
      if (!comm_error) begin
        last_good_pos <= target_pos;
        cmd_target_pos <= target_pos;
        cmd_compensating <= 1'b0;
      end else if (fexp[ssf_pkg::FB_CMD_COMP] && csp_mode) begin
        cmd_target_pos <= last_good_pos;
        cmd_compensating <= 1'b1;
      end else begin
        cmd_target_pos <= target_pos;
        cmd_compensating <= 1'b0;
      end
    end
  end

  // Positioning complete gating
  assign inp_gate = fexp[ssf_pkg::FB_INP_LIMIT] && pole_method_estimate &&
                    !pole_est_done;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      positioning_done_first <= 1'b0;
      positioning_done_second <= 1'b0;
    end else begin
      positioning_done_first <= inp_raw_first && !inp_gate;
      positioning_done_second <= inp_raw_second && !inp_gate;
    end
  end

  // Immediate stop elapsed time, saturating in ms
  always_ff @(posedge ref_clk) begin
    if (!resetn || !imm_stop_active) begin
      stop_ms <= '0;
    end else if (ms_tick && stop_ms != '1) begin
      stop_ms <= stop_ms + 1'b1;
    end
  end

  // A new error wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stop_timeout_err <= 1'b0;
    end else if (imm_stop_active && stop_time != '0 &&
                 {5'h00, stop_ms} > stop_time) begin
      stop_timeout_err <= 1'b1;
    end else if (err_clear) begin
      stop_timeout_err <= 1'b0;
    end
  end

  // The zero setting selects the default; a nonzero level replaces it, above or below
  assign ovs_thresh = (ovs_level == '0) ? OVS_DEF16 : ovs_level;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      overspeed2_err <= 1'b0;
    end else if (imm_stop_active && motor_speed > ovs_thresh) begin
      overspeed2_err <= 1'b1;
    end else if (err_clear) begin
      overspeed2_err <= 1'b0;
    end
  end

  // Power-on delay in 0.1 s steps; the extra setting may change meanwhile
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      init_steps <= '0;
      init_done <= 1'b0;
    end else if (!init_done) begin
      if ({8'h00, init_steps} >= {8'h00, INIT_BASE} + init_extra) begin
        init_done <= 1'b1;
      end else if (step_tick) begin
        init_steps <= init_steps + 1'b1;
      end
    end
  end

  // Second, minute and half hour pacing
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      step_cnt <= '0;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= step_tick && step_cnt == STEP_LAST;
      if (step_tick) begin
        step_cnt <= (step_cnt == STEP_LAST) ? 4'h0 : step_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sec_cnt <= '0;
      min_tick <= 1'b0;
    end else begin
      min_tick <= sec_tick && sec_cnt == SEC_LAST;
      if (sec_tick) begin
        sec_cnt <= (sec_cnt == SEC_LAST) ? 6'h00 : sec_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      min_cnt <= '0;
    end else if (min_tick) begin
      min_cnt <= (min_cnt == MIN_LAST) ? 5'h00 : min_cnt + 1'b1;
    end
  end

  // Load estimation pacing
  assign est_mode = ssf_pkg::ssf_est_t'(est_sel[1:0]);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      load_est_mode <= '0;
      load_est_strobe <= 1'b0;
    end else begin
      load_est_mode <= autotune_en ? est_sel[1:0] : 2'h0;
      if (!autotune_en) begin
        load_est_strobe <= 1'b0;
      end else begin
        unique case (est_mode)
          ssf_pkg::SSF_EST_STOP: load_est_strobe <= 1'b0;
          ssf_pkg::SSF_EST_MINUTE: load_est_strobe <= min_tick;
          ssf_pkg::SSF_EST_SECOND: load_est_strobe <= sec_tick;
          ssf_pkg::SSF_EST_OPTIMUM: load_est_strobe <= load_change;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      nv_save_strobe <= 1'b0;
    end else begin
      nv_save_strobe <= autotune_en && est_mode != ssf_pkg::SSF_EST_STOP &&
                        min_tick && min_cnt == MIN_LAST;
    end
  end

endmodule : ssf_top

// *** verif/ssf_top_sva.sv ***
/*
  Port checker for ssf_top outputs.
  Assumes a bind into ssf_top.
*/
`timescale 1ns/100ps
module ssf_top_sva #(
  parameter int unsigned MAX_SPEED = 5000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Object port
  input wire logic obj_req,
  input wire logic obj_we,
  input wire logic [15:0] obj_index,
  input wire logic [15:0] obj_wdata,
  input wire logic obj_ack,
  input wire logic obj_err,
  // Function outputs
  input wire logic speed_observer_en,
  input wire logic current_resp_en,
  // Position command
  input wire logic csp_mode,
  input wire logic target_valid,
  input wire logic comm_error,
  input wire logic [31:0] target_pos,
  input wire logic [31:0] cmd_target_pos,
  input wire logic cmd_compensating,
  // Positioning complete
  input wire logic inp_raw_first,
  input wire logic inp_raw_second,
  input wire logic pole_method_estimate,
  input wire logic pole_est_done,
  input wire logic positioning_done_first,
  input wire logic positioning_done_second,
  // Stop supervision
  input wire logic imm_stop_active,
  input wire logic [15:0] motor_speed,
  input wire logic err_clear,
  input wire logic stop_timeout_err,
  input wire logic overspeed2_err
);
  // Shadow copies; lag allowed for by stable-value guards
  logic wr_ok, fx_wr, fx6, fx7;
  logic [15:0] ovs, tmo;
  logic [31:0] thr;
  assign wr_ok = obj_req && obj_we;
  assign fx_wr = wr_ok && obj_index == ssf_pkg::IDX_FEXP
    && obj_wdata <= 16'h01FF;
  assign thr = (ovs == 16'h0000) ? MAX_SPEED * ssf_pkg::OVS_NUM
    / ssf_pkg::OVS_DEN : {16'h0000, ovs};
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fx6 <= 1'b1;
      fx7 <= 1'b0;
      ovs <= 16'h0000;
      tmo <= 16'h00C8;
    end else begin
      if (fx_wr) begin
        fx6 <= obj_wdata[6];
        fx7 <= obj_wdata[7];
      end
      if (wr_ok && obj_index == ssf_pkg::IDX_OVS_LEVEL
          && obj_wdata <= 16'h4E20)
        ovs <= obj_wdata;
      if (wr_ok && obj_index == ssf_pkg::IDX_STOP_TIME
          && obj_wdata <= 16'h03E8)
        tmo <= obj_wdata;
    end
  end

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_ack_after_req: assert property (obj_req |=> obj_ack)
    else $error("no answer after request");
  a_ack_has_cause: assert property (obj_ack |-> $past(obj_req))
    else $error("answer without request");
  a_err_with_ack: assert property (obj_err |-> obj_ack)
    else $error("error without answer");
  a_speed_obs_bit: assert property (
    fx_wr |-> ##2 speed_observer_en == $past(obj_wdata[0], 2))
    else $error("speed observer enable wrong");
  a_cur_resp_bit: assert property (
    fx_wr |-> ##2 current_resp_en == $past(obj_wdata[4], 2))
    else $error("current response enable wrong");
  a_target_pass: assert property (
    target_valid && !comm_error |=>
    cmd_target_pos == $past(target_pos) && !cmd_compensating)
    else $error("good target not passed");
  a_target_hold: assert property (
    $past(resetn) && $stable(fx6) && fx6 && target_valid && comm_error
    && csp_mode |=> cmd_compensating && $stable(cmd_target_pos))
    else $error("target not held on error");
  a_done_follow: assert property (
    $past(resetn) && $stable(fx7) && !fx7 |=>
    positioning_done_first == $past(inp_raw_first)
    && positioning_done_second == $past(inp_raw_second))
    else $error("done outputs do not follow raw");
  a_done_gated: assert property (
    $stable(fx7) && fx7 && pole_method_estimate && !pole_est_done |=>
    !positioning_done_first && !positioning_done_second)
    else $error("done outputs before pole known");
  a_ovs_detect: assert property (
    $stable(ovs) && imm_stop_active && motor_speed > thr |=> overspeed2_err)
    else $error("overspeed not flagged");
  a_tmo_off: assert property (
    tmo == 16'h0000 && $stable(tmo) && !stop_timeout_err |=>
    !stop_timeout_err) else $error("timeout while disabled");
  a_err_sticky: assert property (
    stop_timeout_err && !err_clear |=> stop_timeout_err)
    else $error("timeout flag dropped");

  c_fexp_write: cover property (fx_wr);
  c_hold: cover property (cmd_compensating);
  c_overspeed: cover property ($rose(overspeed2_err));
  c_timeout: cover property ($rose(stop_timeout_err));
endmodule : ssf_top_sva

bind ssf_top ssf_top_sva #(.MAX_SPEED(MAX_SPEED)) u_sva (.*);

// *** verif/ssf_ctrl_model.sv ***
/*
  Motion controller model issuing object reads and writes.
  Assumes the object port answers one cycle after each request.
*/
`timescale 1ns/100ps
module ssf_ctrl_model (
  // Clock
  input wire logic ref_clk,
  // Object port
  output logic obj_req,
  output logic obj_we,
  output logic [15:0] obj_index,
  output logic [15:0] obj_wdata,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire logic [15:0] obj_rdata
);
  initial begin
    obj_req = 1'b0;
    obj_we = 1'b0;
    obj_index = 16'h0000;
    obj_wdata = 16'h0000;
  end

  // Gap sets slow spacing; released lines show inverted junk
  task automatic access(input logic we, input logic [15:0] idx,
      input logic [15:0] wd, input int gap, output logic [15:0] rd,
      output logic ack, output logic err);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    obj_req <= 1'b1;
    obj_we <= we;
    obj_index <= idx;
    obj_wdata <= (idx == ssf_pkg::IDX_FEXP) ? wd & ssf_pkg::FEXP_MASK : wd;
    @(posedge ref_clk);
    obj_req <= 1'b0;
    obj_index <= ~idx;
    obj_wdata <= ~obj_wdata;
    #1;
    ack = obj_ack;
    err = obj_err;
    rd = obj_rdata;
  endtask : access
endmodule : ssf_ctrl_model

// *** verif/tb_ssf_top.sv ***
/*
  Testbench for ssf_top: object sequences with expected values.
  Assumes shortened counts: 4 cycles a ms, 8 cycles a 0.1 s step.
*/
`timescale 1ns/100ps
module tb_ssf_top;
  localparam int MS = 4;
  localparam int STEP = 8;
  logic ref_clk = 1'b0, resetn = 1'b0, gain1_sel = 1'b0, csp_mode = 1'b0;
  logic target_valid = 1'b0, comm_error = 1'b0, inp_raw_first = 1'b0;
  logic inp_raw_second = 1'b0, pole_method_estimate = 1'b0;
  logic pole_est_done = 1'b0, imm_stop_active = 1'b0, err_clear = 1'b0;
  logic autotune_en = 1'b0, load_change = 1'b0;
  logic [31:0] target_pos = 32'h0000_0000;
  logic [15:0] motor_speed = 16'h0000;
  logic obj_req, obj_we, obj_ack, obj_err, speed_observer_en;
  logic [15:0] obj_index, obj_wdata, obj_rdata, dist_comp_gain;
  logic [15:0] dist_filter_time;
  logic dist_observer_en, current_resp_en, cmd_compensating;
  logic [31:0] cmd_target_pos;
  logic positioning_done_first, positioning_done_second, init_done;
  logic stop_timeout_err, overspeed2_err, load_est_strobe, nv_save_strobe;
  logic [1:0] load_est_mode;
  int bad_count = 0, n_checks = 0, cyc_n = 0, strobes = 0, s0 = 0;
  wire [2:0] fx_out = {speed_observer_en, dist_observer_en, current_resp_en};
  wire [1:0] done2 = {positioning_done_first, positioning_done_second};

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  ssf_top #(.MS_CYCLES(MS), .STEP_CYCLES(STEP), .MAX_SPEED(5000)) dut (.*);
  ssf_ctrl_model ctl (.*);

  always @(posedge ref_clk) begin
    cyc_n <= resetn ? cyc_n + 1 : 0;
    if (load_est_strobe === 1'b1)
      strobes <= strobes + 1;
  end

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  // Reads are issued slowly, writes promptly
  task automatic xs(input logic we, input logic [15:0] idx,
      input logic [15:0] wd, input logic e, input logic [15:0] x);
    logic [15:0] rd;
    logic ack, err;
    ctl.access(we, idx, wd, we ? 0 : 2, rd, ack, err);
    chk(ack, 1'b1);
    chk(err, e);
    if (!we)
      chk(rd, x);
  endtask : xs

  function automatic logic sig(input int s);
    case (s)
      0: sig = init_done;
      1: sig = stop_timeout_err;
      default: sig = (strobes != s0);
    endcase
  endfunction : sig

  task automatic wait_for(input int s, input int lim);
    for (int i = 0; i < lim && sig(s) !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(sig(s), 1'b1);
    if (sig(s) !== 1'b1)
      conclude();
  endtask : wait_for

  task automatic ovs_probe(input logic [15:0] thr);
    cyc(1);
    imm_stop_active <= 1'b1;
    motor_speed <= thr;
    cyc(3);
    #1;
    chk(overspeed2_err, 1'b0);
    cyc(1);
    motor_speed <= thr + 16'h0001;
    cyc(2);
    #1;
    chk(overspeed2_err, 1'b1);
    cyc(1);
    imm_stop_active <= 1'b0;
    err_clear <= 1'b1;
    cyc(1);
    err_clear <= 1'b0;
    #1;
    chk(overspeed2_err, 1'b0);
  endtask : ovs_probe

  task automatic est(input logic [15:0] sel, input int lim);
    xs(1, 16'h3631, sel, 0, 0);
    cyc(1);
    load_change <= 1'b1;
    cyc(1);
    load_change <= 1'b0;
    #1;
    s0 = strobes;
    chk(load_est_mode, sel);
    if (lim > 0)
      wait_for(2, lim);
  endtask : est

  initial begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    conclude();
  end

  initial begin
    cyc(3);
    resetn <= 1'b1;
    xs(0, 16'h3610, 0, 0, 16'h0040);
    xs(0, 16'h3614, 0, 0, 16'h00C8);
    xs(0, 16'h3615, 0, 0, 16'h0000);
    xs(0, 16'h3618, 0, 0, 16'h0000);
    xs(0, 16'h3623, 0, 0, 16'h0000);
    xs(0, 16'h3624, 0, 0, 16'h0035);
    xs(0, 16'h3631, 0, 0, 16'h0000);
    xs(0, 16'h7777, 0, 1, 16'h0000);
    xs(1, 16'h36F0, 0, 1, 0);
    xs(1, 16'h3618, 16'h0002, 0, 0);
    cyc((ssf_pkg::INIT_BASE_STEPS + 1) * STEP - cyc_n);
    #1;
    chk(init_done, 1'b0);
    wait_for(0, 3 * STEP);
    xs(0, 16'h36F0, 0, 0, 16'h0001);
    xs(1, 16'h3614, 16'h03E9, 1, 0);
    xs(1, 16'h3614, 16'h03E8, 0, 0);
    xs(1, 16'h3624, 16'h0009, 1, 0);
    xs(1, 16'h3624, 16'h09C4, 0, 0);
    xs(1, 16'h3623, 16'hFF9B, 1, 0);
    xs(1, 16'h3623, 16'hFF9C, 0, 0);
    xs(1, 16'h3631, 16'h0004, 1, 0);
    xs(1, 16'h3615, 16'h4E21, 1, 0);
    xs(0, 16'h3624, 0, 0, 16'h09C4);
    chk(dist_comp_gain, 16'hFF9C);
    chk(dist_filter_time, 16'h09C4);
    xs(1, 16'h3610, 16'h0013, 0, 0);
    cyc(1);
    #1;
    chk(fx_out, 3'b111);
    xs(1, 16'h3610, 16'h0006, 0, 0);
    cyc(1);
    #1;
    chk(fx_out, 3'b000);
    cyc(1);
    gain1_sel <= 1'b1;
    cyc(2);
    #1;
    chk(fx_out, 3'b010);
    xs(1, 16'h3610, 16'h0040, 0, 0);
    cyc(1);
    csp_mode <= 1'b1;
    target_valid <= 1'b1;
    target_pos <= 32'h0000_1234;
    cyc(1);
    comm_error <= 1'b1;
    target_pos <= 32'h0000_5678;
    cyc(1);
    target_valid <= 1'b0;
    #1;
    chk(cmd_target_pos, 32'h0000_1234);
    chk(cmd_compensating, 1'b1);
    xs(1, 16'h3610, 16'h0000, 0, 0);
    cyc(1);
    target_valid <= 1'b1;
    cyc(1);
    target_valid <= 1'b0;
    comm_error <= 1'b0;
    #1;
    chk(cmd_target_pos, 32'h0000_5678);
    xs(1, 16'h3610, 16'h0080, 0, 0);
    cyc(1);
    inp_raw_first <= 1'b1;
    inp_raw_second <= 1'b1;
    pole_method_estimate <= 1'b1;
    cyc(2);
    #1;
    chk(done2, 2'b00);
    cyc(1);
    pole_est_done <= 1'b1;
    cyc(2);
    #1;
    chk(done2, 2'b11);
    xs(1, 16'h3610, 16'h0000, 0, 0);
    cyc(1);
    pole_est_done <= 1'b0;
    inp_raw_first <= 1'b0;
    cyc(2);
    #1;
    chk(done2, 2'b01);
    ovs_probe(16'h1770);
    xs(1, 16'h3615, 16'h0064, 0, 0);
    ovs_probe(16'h0064);
    xs(1, 16'h3614, 16'h0002, 0, 0);
    cyc(1);
    imm_stop_active <= 1'b1;
    motor_speed <= 16'h0000;
    cyc(2 * MS);
    #1;
    chk(stop_timeout_err, 1'b0);
    wait_for(1, 3 * MS);
    cyc(1);
    imm_stop_active <= 1'b0;
    err_clear <= 1'b1;
    cyc(1);
    err_clear <= 1'b0;
    xs(1, 16'h3614, 16'h0000, 0, 0);
    cyc(1);
    imm_stop_active <= 1'b1;
    cyc(15 * MS);
    #1;
    chk(stop_timeout_err, 1'b0);
    cyc(1);
    imm_stop_active <= 1'b0;
    autotune_en <= 1'b1;
    est(16'h0002, 11 * STEP);
    est(16'h0003, 4);
    est(16'h0001, 61 * ssf_pkg::STEPS_PER_S * STEP);
    est(16'h0000, 0);
    cyc(12 * STEP);
    #1;
    chk(strobes - s0, 0);
    cyc(1);
    autotune_en <= 1'b0;
    xs(1, 16'h3631, 16'h0002, 0, 0);
    cyc(1);
    #1;
    chk(load_est_mode, 2'b00);
    conclude();
  end
endmodule : tb_ssf_top
